// ### common/stc_pkg.sv
// Constants and types for the transmit character control block
package stc_pkg;
	// Three-level select encoding
	localparam logic [1:0] TRI_LOW      = 2'h0;
	localparam logic [1:0] TRI_MID      = 2'h1;
	localparam logic [1:0] TRI_HIGH     = 2'h2;
	// Character timing: last bit clock count of a character, ten cycles counted 0 to 9
	localparam logic [3:0] CHAR_LAST    = 4'h9;
	// Word sync sequence: 16 characters, index 0 to 15
	localparam logic [3:0] WS_LAST      = 4'hf;
	// Self-test pattern: 511 characters, count 0 to 510
	localparam logic [8:0] BIST_LAST    = 9'h1fe;
	localparam logic [8:0] BIST_SEED    = 9'h1ff;
	// Character codes
	localparam logic [7:0] K28_5        = 8'hbc;
	localparam logic [9:0] VIOL_C07     = 10'h278;
	localparam logic [1:0] TAG_DATA     = 2'h0;
	localparam logic [1:0] TAG_SPECIAL  = 2'h1;
	localparam logic [1:0] TAG_FILL     = 2'h2;
	localparam logic [1:0] TAG_WSYNC    = 2'h3;
	// Latch values after reset
	localparam logic [1:0] BIST_LAT_RST = 2'h3;
	localparam logic [1:0] OE_LAT_RST   = 2'h0;
	// Width of the synchronised pin bundle
	localparam int         PIN_W        = 31;

	typedef enum logic [6:0] {
		KIND_DATA    = 7'h01,
		KIND_FILL    = 7'h02,
		KIND_SPECIAL = 7'h04,
		KIND_WSYNC   = 7'h08,
		KIND_VIOL    = 7'h10,
		KIND_RAW     = 7'h20,
		KIND_BIST    = 7'h40
	} stc_kind_t;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'h1,
		SEQ_WS   = 3'h2,
		SEQ_BIST = 3'h4
	} stc_seq_t;
endpackage : stc_pkg

// ### tb/stc_rx_model.sv
// Remote serial receiver model: rebuilds characters from the primary line
module stc_rx_model (
	// Clock, reset and character timing
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       tx_char_tick,
	// Serial line from the block
	input  wire logic       serial_out_primary,
	// Rebuilt character
	output logic [9:0]      rx_char,
	output logic            rx_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] bit_cnt_r;
	logic [9:0] shift_r;
	////////////////////////////////////////////////////////////////////////////////
	// Ten bits follow each character tick, bit 0 first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_cnt_r <= 4'h0;
			shift_r   <= 10'h000;
			rx_char   <= 10'h000;
			rx_valid  <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (bit_cnt_r != 4'h0) begin
				shift_r   <= {serial_out_primary, shift_r[9:1]};
				bit_cnt_r <= bit_cnt_r - 4'h1;
				if (bit_cnt_r == 4'h1) begin
					rx_char  <= {serial_out_primary, shift_r[9:1]};
					rx_valid <= 1'b1;
				end
			end
			if (tx_char_tick)
				bit_cnt_r <= 4'ha;
		end
	end
endmodule : stc_rx_model

// ### tb/testbench.sv
// Self-checking bench for the transmit character control block
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import stc_pkg::*;
	logic        clk = 0, rst = 1, tx_parity_bit, special_code_select, tx_input_clock = 0;
	logic        tx_rate_half = 0, rx_clock_select = 1, loopback_enable = 0, device_reset_n = 0;
	logic        selftest_latch_enable = 0, output_latch_enable = 0;
	logic [7:0]  tx_data;
	logic [1:0]  tx_ctrl_bits, parity_control = TRI_MID, tx_input_clock_select = TRI_LOW;
	logic [1:0]  speed_range_select = TRI_HIGH, shared_enable_bits = 2'h3;
	logic [3:0]  tx_mode_select = {TRI_MID, TRI_HIGH};
	logic        serial_out_primary, serial_out_primary_en, serial_out_secondary, serial_out_secondary_en;
	logic [9:0]  tx_char, rx_char;
	stc_kind_t   tx_char_kind;
	logic        tx_char_tick, tx_parity_error, tx_power_down, bist_rx_enable, cfg_invalid, rx_valid;
	int          miscompares = 0, num_checks = 0;
	logic [9:0]  exp_q[$];
	logic [10:0] ser_q[$];
	logic [10:0] sv;
	logic        armed = 0, ser_on = 0;

	stc_tx_char_ctrl u_stc_tx_char_ctrl (.clk(clk), .rst(rst), .tx_data(tx_data), .tx_parity_bit(tx_parity_bit),
		.tx_ctrl_bits(tx_ctrl_bits), .special_code_select(special_code_select), .tx_input_clock(tx_input_clock),
		.tx_mode_select(tx_mode_select), .parity_control(parity_control),
		.tx_input_clock_select(tx_input_clock_select), .tx_rate_half(tx_rate_half),
		.speed_range_select(speed_range_select), .rx_clock_select(rx_clock_select),
		.loopback_enable(loopback_enable), .shared_enable_bits(shared_enable_bits),
		.selftest_latch_enable(selftest_latch_enable), .output_latch_enable(output_latch_enable),
		.device_reset_n(device_reset_n), .serial_out_primary(serial_out_primary),
		.serial_out_primary_en(serial_out_primary_en), .serial_out_secondary(serial_out_secondary),
		.serial_out_secondary_en(serial_out_secondary_en), .tx_char(tx_char), .tx_char_kind(tx_char_kind),
		.tx_char_tick(tx_char_tick), .tx_parity_error(tx_parity_error), .tx_power_down(tx_power_down),
		.bist_rx_enable(bist_rx_enable), .cfg_invalid(cfg_invalid));
	stc_rx_model u_stc_rx_model (.clk(clk), .rst(rst), .tx_char_tick(tx_char_tick),
		.serial_out_primary(serial_out_primary), .rx_char(rx_char), .rx_valid(rx_valid));

	always #12.5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	// One character per slot, with an input clock pulse inside the slot
	task automatic put(input logic [1:0] c, input logic s, input logic [7:0] d, input logic bad);
		@(posedge clk iff tx_char_tick === 1'b1);
		@(negedge clk);
		tx_ctrl_bits = c;
		special_code_select = s;
		tx_data = d;
		tx_parity_bit = ~^d ^ bad;
		repeat (2) @(negedge clk);
		tx_input_clock = 1'b1;
		repeat (3) @(negedge clk);
		tx_input_clock = 1'b0;
	endtask : put
	task automatic exn(input logic [9:0] v, input int n);
		repeat (n) exp_q.push_back(v);
	endtask : exn
	task automatic idle(input int n);
		repeat (n) put(2'h1, 1'b0, K28_5, 1'b0);
	endtask : idle
	task automatic latch(input logic oe, input logic [1:0] b);
		@(negedge clk);
		shared_enable_bits = b;
		{output_latch_enable, selftest_latch_enable} = oe ? 2'h2 : 2'h1;
		repeat (4) @(negedge clk);
		{output_latch_enable, selftest_latch_enable} = 2'h0;
		repeat (2) @(negedge clk);
		shared_enable_bits = ~b;
		repeat (6) @(negedge clk);
	endtask : latch
	// Length of the next run of one kind; tx_data and tx_ctrl_bits are scrambled meanwhile
	task automatic run(input stc_kind_t k, input int n0, output int n, output logic [9:0] nxt);
		int w;
		logic hit;
		n = n0;
		w = 0;
		forever begin
			@(posedge clk iff tx_char_tick === 1'b1);
			hit = (tx_char_kind === k);
			nxt = tx_char;
			if (!hit && (n > 0 || w > 40))
				break;
			if (hit)
				n++;
			else
				w++;
			@(negedge clk);
			tx_data = 8'($urandom);
			tx_ctrl_bits = 2'($urandom);
		end
	endtask : run
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (rx_valid === 1'b1 && ser_q.size() > 0) begin
			sv = ser_q.pop_front();
			if (sv[10])
				chk(rx_char, sv[9:0], "serial char");
		end
		if (tx_char_tick === 1'b1) begin
			ser_q.push_back({ser_on, tx_char});
			if (exp_q.size() > 0 && (armed || tx_char === exp_q[0])) begin
				armed = 1'b1;
				chk(tx_char, exp_q.pop_front(), "char");
				if (exp_q.size() == 0)
					armed = 1'b0;
			end
		end
	end
	initial begin
		#1ms;
		miscompares++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		report_and_stop();
	end
	initial begin
		logic [7:0] b;
		logic [1:0] lo;
		int         n;
		logic [9:0] c0, c1;
		{tx_ctrl_bits, special_code_select, tx_data, tx_parity_bit} = {2'h1, 1'b0, K28_5, ~^K28_5};
		void'($urandom(36));
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		device_reset_n = 1'b1;
		repeat (4) @(negedge clk);
		chk(10'(serial_out_primary_en | serial_out_secondary_en), 10'h0, "drivers after reset");
		chk(10'(tx_power_down), 10'h1, "power down");
		latch(1'b1, 2'h3);
		chk(10'({serial_out_secondary_en, serial_out_primary_en}), 10'h3, "both drivers");
		ser_on = 1'b1;
		for (int m = 0; m < 6; m++) begin
			lo = 2'(m % 3);
			tx_mode_select = {(m < 3) ? TRI_MID : TRI_HIGH, lo};
			idle(4);
			b = 8'($urandom);
			put(2'h0, 1'($urandom), b, 1'b0);
			exn({TAG_DATA, b}, 1);
			put(2'h1, 1'b0, 8'($urandom), 1'b0);
			exn({TAG_FILL, K28_5}, 1);
			put((lo == TRI_LOW) ? 2'h1 : (lo == TRI_MID) ? 2'h3 : 2'h2, lo == TRI_LOW, b, 1'b0);
			exn({TAG_SPECIAL, b}, 1);
			put((lo == TRI_HIGH) ? 2'h0 : 2'h2, 1'($urandom), ~b, 1'b0);
			exn({TAG_DATA, ~b}, 1);
			put((lo == TRI_MID) ? 2'h1 : 2'h3, lo == TRI_MID, b, 1'b0);
			exn({TAG_WSYNC, K28_5}, 16);
			repeat (15) put(2'h0, 1'b0, 8'($urandom), 1'b0);
		end
		ser_on = 1'b0;
		idle(4);
		tx_mode_select = {TRI_MID, TRI_HIGH};
		idle(4);
		b = 8'($urandom);
		put(2'h0, 1'b0, b, 1'b0);
		exn({TAG_DATA, b}, 1);
		put(2'h3, 1'b0, b, 1'b0);
		exn({TAG_WSYNC, K28_5}, 32);
		repeat (14) put(2'($urandom), 1'b0, 8'($urandom), 1'($urandom));
		put(2'h3, 1'b0, b, 1'b0);
		repeat (15) put(2'($urandom), 1'b0, 8'($urandom), 1'($urandom));
		put(2'h2, 1'b0, 8'($urandom), 1'b1);
		put(2'h0, 1'b0, ~b, 1'b0);
		exn({TAG_DATA, ~b}, 1);
		idle(4);
		tx_mode_select = {TRI_HIGH, TRI_HIGH};
		idle(4);
		put(2'h0, 1'b0, b, 1'b0);
		exn({TAG_DATA, b}, 1);
		put(2'h3, 1'b0, b, 1'b0);
		exn({TAG_WSYNC, K28_5}, 4);
		repeat (3) put(2'h0, 1'b0, 8'($urandom), 1'b0);
		put(2'h2, 1'b0, ~b, 1'b0);
		exn({TAG_SPECIAL, ~b}, 1);
		put(2'h3, 1'b0, b, 1'b0);
		exn({TAG_WSYNC, K28_5}, 2);
		put(2'h0, 1'b0, b, 1'b0);
		put(2'h0, 1'b0, b, 1'b1);
		exn(VIOL_C07, 1);
		put(2'h0, 1'b0, ~b, 1'b0);
		exn({TAG_DATA, ~b}, 1);
		for (int p = 0; p < 2; p++) begin
			idle(4);
			parity_control = p ? TRI_HIGH : TRI_LOW;
			idle(4);
			put(2'h0, 1'b0, b, 1'b0);
			put(2'h0, 1'b0, ~b, 1'b1);
			exn({TAG_DATA, b}, 1);
			exn(p ? VIOL_C07 : {TAG_DATA, ~b}, 1);
		end
		idle(4);
		tx_mode_select = {TRI_LOW, TRI_LOW};
		idle(4);
		put(2'h3, 1'b0, b, 1'b0);
		exn({2'h3, b}, 1);
		put(2'h0, 1'b0, ~b, 1'b1);
		exn(VIOL_C07, 1);
		idle(4);
		tx_mode_select = {TRI_MID, TRI_HIGH};
		tx_input_clock_select = TRI_MID;
		tx_rate_half = 1'b1;
		repeat (8) @(negedge clk);
		chk(10'(cfg_invalid), 10'h1, "invalid config");
		tx_rate_half = 1'b0;
		idle(4);
		put(2'h0, 1'b0, b, 1'b0);
		put(2'h2, 1'b0, ~b, 1'b0);
		exn({TAG_DATA, b}, 1);
		exn({TAG_SPECIAL, ~b}, 1);
		idle(4);
		tx_input_clock_select = TRI_LOW;
		loopback_enable = 1'b1;
		repeat (30) @(negedge clk);
		repeat (20) begin
			@(negedge clk);
			chk(10'({serial_out_secondary, serial_out_primary}), 10'h3, "loopback level");
		end
		loopback_enable = 1'b0;
		latch(1'b1, 2'h2);
		chk(10'({serial_out_secondary_en, serial_out_primary_en, serial_out_primary}), 10'h4, "one driver");
		chk(10'(tx_power_down), 10'h0, "one driver power");
		latch(1'b1, 2'h0);
		chk(10'(tx_power_down), 10'h1, "no driver power");
		latch(1'b1, 2'h3);
		rx_clock_select = 1'b0;
		latch(1'b0, 2'h0);
		chk(10'(bist_rx_enable), 10'h1, "receive checker on");
		run(KIND_WSYNC, 0, n, c0);
		chk(10'(n), 10'd16, "sync before pass");
		chk(10'(c0[9]), 10'(c0[0] ^ c0[8]), "pattern top bit");
		run(KIND_BIST, 1, n, c1);
		chk(10'(n), 10'd511, "pattern length");
		run(KIND_WSYNC, 1, n, c1);
		chk(10'(n), 10'd16, "sync before next pass");
		chk(c1, c0, "pattern repeats");
		latch(1'b0, 2'h3);
		chk(10'(bist_rx_enable), 10'h0, "receive checker off");
		latch(1'b0, 2'h0);
		device_reset_n = 1'b0;
		repeat (6) @(negedge clk);
		chk(10'({serial_out_secondary_en, serial_out_primary_en, bist_rx_enable}), 10'h0, "device reset");
		chk(10'(exp_q.size()), 10'h0, "pending chars");
		report_and_stop();
	end
endmodule : testbench

// ### verilog/stc_tx_char_ctrl.sv
// Transmit character control: mode decode, word sync, self-test, output enables, shifter
// Summary of operation
// RQ1: Modes 3/6: data, fill/special by select, sync
// RQ2: Modes 4/7: select plus ctrl0 starts sync
// RQ3: Modes 5/8: ctrl 00/01/10/11 picks character kind
// RQ4: Atomic sync runs 16 characters, inputs ignored
// RQ5: Start seen at sequence end restarts sequence
// RQ6: Atomic start needs odd parity; rest unchecked
// RQ7: Interruptible sync ends on non-00 control
// RQ8: Interruptible parity error aborts, sends violation
// RQ9: Input register clock: reference or input clock
// RQ10: Host never selects input clock with half rate
// RQ11: Latched low enable bits enable self-test
// RQ12: Self-test latch transparent, reset disables self-test
// RQ13: Self-test LFSR gives repeating 511-character pattern
// RQ14: Reference rx clocking: sync precedes each pass
// RQ15: Self-test ignores parallel data and control
// RQ16: Loopback drives enabled outputs constant one
// RQ17: Output latch: bit1 secondary, bit0 primary
// RQ18: Both drivers off puts logic in low power
// RQ19: Device reset disables both serial drivers
// RQ20: Bit clock is ten per character
// RQ21: Host avoids low speed range with half rate
// RQ22: Characters shift out least significant bit first
// RQ23: Parity checked unless parity control low
// RQ24: After sync ends, normal encoding resumes
module stc_tx_char_ctrl (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Parallel character inputs
	input  wire logic [7:0]        tx_data,
	input  wire logic              tx_parity_bit,
	input  wire logic [1:0]        tx_ctrl_bits,
	input  wire logic              special_code_select,
	input  wire logic              tx_input_clock,
	// Configuration pins, three-level ones as two bits
	input  wire logic [3:0]        tx_mode_select,
	input  wire logic [1:0]        parity_control,
	input  wire logic [1:0]        tx_input_clock_select,
	input  wire logic              tx_rate_half,
	input  wire logic [1:0]        speed_range_select,
	input  wire logic              rx_clock_select,
	input  wire logic              loopback_enable,
	// Enable latches and device reset
	input  wire logic [1:0]        shared_enable_bits,
	input  wire logic              selftest_latch_enable,
	input  wire logic              output_latch_enable,
	input  wire logic              device_reset_n,
	// Serial drivers
	output logic                   serial_out_primary,
	output logic                   serial_out_primary_en,
	output logic                   serial_out_secondary,
	output logic                   serial_out_secondary_en,
	// Status
	output logic [9:0]             tx_char,
	output stc_pkg::stc_kind_t     tx_char_kind,
	output logic                   tx_char_tick,
	output logic                   tx_parity_error,
	output logic                   tx_power_down,
	output logic                   bist_rx_enable,
	output logic                   cfg_invalid
);
	import stc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [PIN_W-1:0] sync1_r;
	logic [PIN_W-1:0] sync2_r;
	logic             tx_input_clock_d_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {tx_data, tx_parity_bit, tx_ctrl_bits, special_code_select, tx_input_clock,
				tx_mode_select, parity_control, tx_input_clock_select, tx_rate_half,
				speed_range_select, rx_clock_select, loopback_enable, shared_enable_bits,
				selftest_latch_enable, output_latch_enable, device_reset_n};
			sync2_r <= sync1_r;
		end
	end

	logic [7:0] data_q;
	logic       par_q;
	logic [1:0] ct_q;
	logic       sc_q;
	logic       tx_input_clock_q;
	logic [3:0] mode_q;
	logic [1:0] parity_control_q;
	logic [1:0] cksel_q;
	logic       half_q;
	logic [1:0] spd_q;
	logic       rxck_q;
	logic       loop_q;
	logic [1:0] boe_q;
	logic       ble_q;
	logic       output_latch_enable_q;
	logic       dev_rst_q;
	logic       dev_rst_n_q;

	assign {data_q, par_q, ct_q, sc_q, tx_input_clock_q, mode_q, parity_control_q, cksel_q, half_q, spd_q,
		rxck_q, loop_q, boe_q, ble_q, output_latch_enable_q, dev_rst_n_q} = sync2_r;
	assign dev_rst_q = ~dev_rst_n_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			tx_input_clock_d_r <= 1'b0;
		else
			tx_input_clock_d_r <= tx_input_clock_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Character rate divider: clk is the bit clock, ten bits per character

	logic [3:0] div_r;
	logic       tick_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			div_r  <= (div_r == CHAR_LAST) ? 4'h0 : div_r + 4'h1; // RQ20
			tick_r <= (div_r == CHAR_LAST); // RQ20
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Enable latches, transparent while their enable is high

	logic [1:0] bist_lat_r;
	logic [1:0] oe_lat_r;
	logic       pd;
	logic       bist_on;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			bist_lat_r <= BIST_LAT_RST;
		else if (dev_rst_q)
			bist_lat_r <= BIST_LAT_RST; // RQ12
		else if (ble_q)
			bist_lat_r <= boe_q; // RQ12
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			oe_lat_r <= OE_LAT_RST;
		else if (dev_rst_q)
			oe_lat_r <= OE_LAT_RST; // RQ19
		else if (output_latch_enable_q)
			oe_lat_r <= boe_q; // RQ17
	end

	assign pd      = (oe_lat_r == 2'h0); // RQ18
	assign bist_on = ~bist_lat_r[1]; // RQ11

	////////////////////////////////////////////////////////////////////////
	// Input register

	logic [11:0] in_r;
	logic        cap_ev;

	// Reference clocking captures on the character clock, otherwise on input clock rise
	assign cap_ev = (cksel_q == TRI_LOW) ? tick_r : (tx_input_clock_q & ~tx_input_clock_d_r); // RQ9

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			in_r <= '0;
		else if (cap_ev)
			in_r <= {sc_q, ct_q, par_q, data_q}; // RQ9
	end

	////////////////////////////////////////////////////////////////////////
	// Character decode and sequencing

	function automatic stc_kind_t decode_kind(input logic [1:0] mlow, input logic sc, input logic [1:0] ct);
		stc_kind_t k;
		k = KIND_DATA;
		case (mlow)
			TRI_LOW: begin
				if (ct == 2'h1)
					k = sc ? KIND_SPECIAL : KIND_FILL; // RQ1
				else if (ct == 2'h3)
					k = KIND_WSYNC; // RQ1
			end
			TRI_MID: begin
				if (ct[0] && sc)
					k = KIND_WSYNC; // RQ2
				else if (ct == 2'h1)
					k = KIND_FILL; // RQ2
				else if (ct == 2'h3)
					k = KIND_SPECIAL; // RQ2
			end
			default: begin
				case (ct)
					2'h1:    k = KIND_FILL; // RQ3
					2'h2:    k = KIND_SPECIAL; // RQ3
					2'h3:    k = KIND_WSYNC; // RQ3
					default: k = KIND_DATA;
				endcase
			end
		endcase
		return k;
	endfunction : decode_kind

	function automatic logic [9:0] char_code(input stc_kind_t k, input logic [7:0] d);
		logic [9:0] c;
		c = {TAG_DATA, d};
		case (k)
			KIND_SPECIAL: c = {TAG_SPECIAL, d};
			KIND_FILL:    c = {TAG_FILL, K28_5};
			KIND_WSYNC:   c = {TAG_WSYNC, K28_5};
			KIND_VIOL:    c = VIOL_C07;
			default:      c = {TAG_DATA, d};
		endcase
		return c;
	endfunction : char_code

	stc_seq_t   st_r;
	stc_seq_t   st_nxt;
	logic [3:0] idx_r;
	logic [3:0] idx_nxt;
	logic [8:0] lfsr_r;
	logic [8:0] lfsr_nxt;
	logic [8:0] bcnt_r;
	logic [8:0] bcnt_nxt;
	stc_kind_t  kind_r;
	stc_kind_t  kind_nxt;
	stc_kind_t  ck;
	logic [9:0] char_r;
	logic [9:0] char_nxt;
	logic       perr_r;
	logic       perr_nxt;
	logic       bad;
	logic       atomic;
	logic       ws_run;

	assign ck     = decode_kind(mode_q[1:0], in_r[11], in_r[10:9]);
	assign bad    = (parity_control_q != TRI_LOW) && ~^in_r[8:0]; // RQ23
	assign atomic = (mode_q[3:2] == TRI_MID);
	// Interruptible sync continues only on clean 00 characters
	assign ws_run = (st_r == SEQ_WS) && (atomic || (!bad && in_r[10:9] == 2'h0)); // RQ4 RQ7 RQ8

	always_comb begin
		st_nxt   = st_r;
		idx_nxt  = idx_r;
		lfsr_nxt = BIST_SEED;
		bcnt_nxt = '0;
		kind_nxt = kind_r;
		char_nxt = char_r;
		perr_nxt = 1'b0;
		if (bist_on) begin // RQ15
			lfsr_nxt = lfsr_r;
			bcnt_nxt = bcnt_r;
			if (st_r == SEQ_WS || (st_r == SEQ_IDLE && !rxck_q)) begin // RQ14
				kind_nxt = KIND_WSYNC;
				char_nxt = char_code(KIND_WSYNC, 8'h00);
				st_nxt   = (st_r == SEQ_WS && idx_r == WS_LAST) ? SEQ_BIST : SEQ_WS;
				idx_nxt  = (st_r == SEQ_WS) ? idx_r + 4'h1 : 4'h1;
			end else begin
				kind_nxt = KIND_BIST; // RQ13
				char_nxt = {lfsr_r[0] ^ lfsr_r[8], lfsr_r}; // RQ13
				lfsr_nxt = {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]}; // RQ13
				bcnt_nxt = bcnt_r + 9'h001;
				st_nxt   = SEQ_BIST;
				if (bcnt_r == BIST_LAST) begin
					bcnt_nxt = '0;
					lfsr_nxt = BIST_SEED; // RQ13
					if (!rxck_q) begin
						st_nxt  = SEQ_WS; // RQ14
						idx_nxt = 4'h0;
					end
				end
			end
		end else if (mode_q[3:2] == TRI_LOW) begin
			st_nxt   = SEQ_IDLE;
			idx_nxt  = 4'h0;
			perr_nxt = bad;
			kind_nxt = bad ? KIND_VIOL : KIND_RAW;
			char_nxt = bad ? VIOL_C07 : {in_r[10:9], in_r[7:0]};
		end else if (ws_run) begin
			kind_nxt = KIND_WSYNC;
			char_nxt = char_code(KIND_WSYNC, 8'h00);
			if (idx_r == WS_LAST) begin
				idx_nxt = 4'h0;
				// A clean start seen on the last character restarts at once
				st_nxt  = (atomic && ck == KIND_WSYNC && !bad) ? SEQ_WS : SEQ_IDLE; // RQ5 RQ24
			end else begin
				idx_nxt = idx_r + 4'h1; // RQ4
			end
		end else begin
			st_nxt   = SEQ_IDLE; // RQ24
			idx_nxt  = 4'h0;
			perr_nxt = bad;
			if (bad) begin
				kind_nxt = KIND_VIOL; // RQ6 RQ8
				char_nxt = VIOL_C07;
			end else begin
				kind_nxt = ck; // RQ7
				char_nxt = char_code(ck, in_r[7:0]);
				if (ck == KIND_WSYNC) begin
					st_nxt  = SEQ_WS;
					idx_nxt = 4'h1;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r   <= SEQ_IDLE;
			idx_r  <= '0;
			lfsr_r <= BIST_SEED;
			bcnt_r <= '0;
			kind_r <= KIND_FILL;
			char_r <= {TAG_FILL, K28_5};
			perr_r <= 1'b0;
		end else if (dev_rst_q) begin
			st_r   <= SEQ_IDLE;
			idx_r  <= '0;
			lfsr_r <= BIST_SEED;
			bcnt_r <= '0;
			kind_r <= KIND_FILL;
			char_r <= {TAG_FILL, K28_5};
			perr_r <= 1'b0;
		end else if (tick_r && !pd) begin // RQ18
			st_r   <= st_nxt;
			idx_r  <= idx_nxt;
			lfsr_r <= lfsr_nxt;
			bcnt_r <= bcnt_nxt;
			kind_r <= kind_nxt;
			char_r <= char_nxt;
			perr_r <= perr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shifter and serial drivers

	logic [9:0] shift_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			shift_r <= '0;
		else if (pd)
			shift_r <= '0; // RQ18
		else if (tick_r)
			shift_r <= char_r;
		else
			shift_r <= {1'b0, shift_r[9:1]}; // RQ22
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			serial_out_primary      <= 1'b0;
			serial_out_primary_en   <= 1'b0;
			serial_out_secondary    <= 1'b0;
			serial_out_secondary_en <= 1'b0;
			tx_char                 <= '0;
			tx_char_kind            <= KIND_FILL;
			tx_char_tick            <= 1'b0;
			tx_parity_error         <= 1'b0;
			tx_power_down           <= 1'b1;
			bist_rx_enable          <= 1'b0;
			cfg_invalid             <= 1'b0;
		end else begin
			serial_out_primary      <= oe_lat_r[0] & (loop_q | shift_r[0]); // RQ16 RQ17
			serial_out_primary_en   <= oe_lat_r[0]; // RQ17
			serial_out_secondary    <= oe_lat_r[1] & (loop_q | shift_r[0]); // RQ16 RQ17
			serial_out_secondary_en <= oe_lat_r[1]; // RQ17
			tx_char                 <= char_r;
			tx_char_kind            <= kind_r;
			tx_char_tick            <= tick_r;
			tx_parity_error         <= perr_r;
			tx_power_down           <= pd; // RQ18
			bist_rx_enable          <= ~bist_lat_r[0]; // RQ11
			cfg_invalid             <= half_q && (cksel_q != TRI_LOW || spd_q == TRI_LOW); // RQ10 RQ21
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_atomic_hold: assert property (tick_r && !pd && !dev_rst_q && !bist_on && atomic && st_r == SEQ_WS &&
		idx_r != WS_LAST |=> st_r == SEQ_WS && kind_r == KIND_WSYNC) else $error("atomic sync cut short"); // RQ4
	a_atomic_restart: assert property (tick_r && !pd && !dev_rst_q && !bist_on && atomic && st_r == SEQ_WS &&
		idx_r == WS_LAST && ck == KIND_WSYNC && !bad |=> st_r == SEQ_WS && idx_r == 4'h0)
		else $error("sync did not restart"); // RQ5
	a_intr_abort: assert property (tick_r && !pd && !dev_rst_q && !bist_on && mode_q[3:2] == TRI_HIGH &&
		st_r == SEQ_WS && !bad && in_r[10:9] != 2'h0 && in_r[10:9] != 2'h3 |=> st_r == SEQ_IDLE)
		else $error("sync not terminated"); // RQ7
	a_perr_viol: assert property (tick_r && !pd && !dev_rst_q && !bist_on && mode_q[3:2] == TRI_HIGH &&
		st_r == SEQ_WS && bad |=> kind_r == KIND_VIOL && char_r == VIOL_C07) else $error("no violation"); // RQ8
	a_bist_ignore: assert property (tick_r && !pd && !dev_rst_q && bist_on |=>
		kind_r == KIND_BIST || kind_r == KIND_WSYNC) else $error("bist used inputs"); // RQ15
	a_lsb_first: assert property (tick_r && !pd |=> shift_r == $past(char_r) ##1
		($past(pd) || shift_r[8:0] == $past(char_r[9:1], 2)))
		else $error("shift order wrong"); // RQ22
	a_loop_one: assert property (loop_q && oe_lat_r[0] |=> serial_out_primary && serial_out_primary_en)
		else $error("loopback not one"); // RQ16
	a_oe_reset: assert property (dev_rst_q |=> oe_lat_r == OE_LAT_RST ##1 !serial_out_primary_en &&
		!serial_out_secondary_en) else $error("drivers not off"); // RQ19
	a_bist_latch: assert property (!ble_q && !dev_rst_q |=> $stable(bist_lat_r))
		else $error("bist latch moved"); // RQ12
	a_power_down: assert property (oe_lat_r == 2'h0 |=> tx_power_down && $stable(st_r))
		else $error("not in low power"); // RQ18

	c_ws_done: cover property (st_r == SEQ_WS && idx_r == WS_LAST && tick_r ##1 st_r == SEQ_IDLE);
	c_intr_abort: cover property (tick_r && st_r == SEQ_WS && !atomic && in_r[10:9] != 2'h0);
	c_bist_wrap: cover property (tick_r && st_r == SEQ_BIST && bcnt_r == BIST_LAST);
	c_loopback: cover property (loop_q && oe_lat_r == 2'h3);
endmodule : stc_tx_char_ctrl
